/* verilog/pcm_pkg.sv */
package pcm_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] MODE_ADDR     = 8'hd9;
	localparam logic [7:0] CTRL_ADDR     = 8'hd8;
	localparam logic [7:0] MODE_RESET    = 8'h40;
	localparam int         IDLE_BIT      = 7;
	localparam int         WDOG_EN_BIT   = 6;
	localparam int         WDOG_LOCK_BIT = 5;
	localparam int         SRC_LSB       = 1;
	localparam int         IRQ_EN_BIT    = 0;
	localparam int         OVF_BIT       = 7;
	localparam int         RUN_BIT       = 6;
	// ==========================================
	// Timebase sources
	localparam logic [2:0] SRC_DIV12  = 3'h0;
	localparam logic [2:0] SRC_DIV4   = 3'h1;
	localparam logic [2:0] SRC_T0OVF  = 3'h2;
	localparam logic [2:0] SRC_EXTCNT = 3'h3;
	localparam logic [2:0] SRC_SYS    = 3'h4;
	localparam logic [2:0] SRC_EXT8   = 3'h5;
	localparam int         DIV12_CNT  = 12;
	localparam int         DIV4_CNT   = 4;
	localparam int         EXT_DIV    = 8;
endpackage : pcm_pkg

/* verilog/pcm_mode_ctrl.sv */
// Contract
// - Codes 000, 001, 100 tick on sysclk/12, sysclk/4, every sysclk.
// - Code 010 ticks on timer 0 overflow; code 111 reserved, no ticks.
// - Code 011 counts falling edges of external count input, at most sysclk/4.
// - Code 101 ticks on external clock divided by eight, synchronised.
// - Interrupt requested when overflow flag set and enable bit is one.
// - Watchdog enable bit resets to one.
// - Lock set keeps watchdog enabled until reset; otherwise clearing disables.
// - While watchdog enabled, source field and idle-suspend writes are ignored.
// - Overflow flag set on 0xffff to 0x0000 roll, held until cleared.
module pcm_mode_ctrl (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic        wr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        cpu_idle_i,
	input  wire logic        t0_ovf_i,
	input  wire logic        ext_count_i,
	input  wire logic        ext_clk_i,
	output logic      [7:0]  mode_rdata_o,
	output logic      [7:0]  ctrl_rdata_o,
	output logic      [15:0] count_o,
	output logic             tick_o,
	output logic             wdog_enabled_o,
	output logic             irq_o
);
	// ==========================================
	// Register writes
	logic [7:0]  mode_ff;
	logic        ovf_ff;
	logic        run_ff;
	logic [15:0] cnt_ff;
	wire         wr_mode = wr_i && (addr_i == pcm_pkg::MODE_ADDR);
	wire         wr_ctrl = wr_i && (addr_i == pcm_pkg::CTRL_ADDR);
	wire         wd_on   = mode_ff[pcm_pkg::WDOG_EN_BIT] | mode_ff[pcm_pkg::WDOG_LOCK_BIT];
	wire         locked  = mode_ff[pcm_pkg::WDOG_LOCK_BIT];
	wire [2:0]   src     = mode_ff[pcm_pkg::SRC_LSB +: 3];
	wire         new_lock = locked | wdata_i[pcm_pkg::WDOG_LOCK_BIT];
	wire         new_en   = locked | wdata_i[pcm_pkg::WDOG_EN_BIT] | new_lock;
	wire [7:0]   nxt_mode = {
		wd_on ? mode_ff[pcm_pkg::IDLE_BIT] : wdata_i[pcm_pkg::IDLE_BIT],
		new_en, new_lock, 1'b0,
		wd_on ? src : wdata_i[pcm_pkg::SRC_LSB +: 3],
		wdata_i[pcm_pkg::IRQ_EN_BIT]};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_ff <= pcm_pkg::MODE_RESET;
		else if (wr_mode)
			mode_ff <= nxt_mode;
	end

	// ==========================================
	// Input synchronisers
	logic [1:0] xcnt_sync_ff;
	logic       xcnt_prev_ff;
	logic [1:0] ext_sync_ff;
	logic       ext_prev_ff;
	logic [2:0] ext_div_ff;
	logic       t0_prev_ff;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// Reset levels match each pin's idle level, so no false edge follows
			xcnt_sync_ff <= 2'h3;
			xcnt_prev_ff <= 1'b1;
			ext_sync_ff <= 2'h0;
			ext_prev_ff <= 1'b0;
			ext_div_ff  <= 3'h0;
			t0_prev_ff  <= 1'b0;
		end
		else
		begin
			xcnt_sync_ff <= {xcnt_sync_ff[0], ext_count_i};
			xcnt_prev_ff <= xcnt_sync_ff[1];
			ext_sync_ff <= {ext_sync_ff[0], ext_clk_i};
			ext_prev_ff <= ext_sync_ff[1];
			t0_prev_ff  <= t0_ovf_i;
			if (ext_sync_ff[1] && !ext_prev_ff)
				ext_div_ff <= ext_div_ff + 3'h1;
		end
	end
	// External clock is sampled, so it must run below half the system clock.
	wire ext_rise  = ext_sync_ff[1] && !ext_prev_ff;
	wire ext_tick  = ext_rise && (ext_div_ff == 3'(pcm_pkg::EXT_DIV - 1));
	wire xcnt_fall = xcnt_prev_ff && !xcnt_sync_ff[1];
	wire t0_tick   = t0_ovf_i && !t0_prev_ff;

	// ==========================================
	// Prescaler
	logic [3:0] pre_ff;
	wire        pre_wrap12 = (pre_ff == 4'(pcm_pkg::DIV12_CNT - 1));
	wire        div4_tick  = (pre_ff[1:0] == 2'h3);
	always_ff @(posedge clk_i)
	begin
		if (rst_i || pre_wrap12)
			pre_ff <= 4'h0;
		else
			pre_ff <= pre_ff + 4'h1;
	end

	logic sel_tick;
	always_comb
	begin
		unique case (src)
			pcm_pkg::SRC_DIV12: sel_tick = pre_wrap12;
			pcm_pkg::SRC_DIV4:  sel_tick = div4_tick;
			pcm_pkg::SRC_T0OVF: sel_tick = t0_tick;
			pcm_pkg::SRC_EXTCNT: sel_tick = xcnt_fall;
			pcm_pkg::SRC_SYS:   sel_tick = 1'b1;
			pcm_pkg::SRC_EXT8:  sel_tick = ext_tick;
			default:            sel_tick = 1'b0;
		endcase
	end
	// Watchdog forces the counter on regardless of the run bit.
	wire running = run_ff || wd_on;
	wire halted  = mode_ff[pcm_pkg::IDLE_BIT] && cpu_idle_i;
	wire adv     = sel_tick && running && !halted;
	wire roll    = adv && (cnt_ff == 16'hffff);

	// ==========================================
	// Counter and overflow flag
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_ff <= 16'h0000;
			ovf_ff <= 1'b0;
			run_ff <= 1'b0;
			tick_o <= 1'b0;
		end
		else
		begin
			tick_o <= adv;
			if (adv)
				cnt_ff <= cnt_ff + 16'h0001;
			if (wr_ctrl)
				run_ff <= wdata_i[pcm_pkg::RUN_BIT];
			// Set wins over a same-cycle software clear
			if (roll)
				ovf_ff <= 1'b1;
			else if (wr_ctrl)
				ovf_ff <= wdata_i[pcm_pkg::OVF_BIT];
		end
	end

	wire nxt_irq = ovf_ff && mode_ff[pcm_pkg::IRQ_EN_BIT];
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_o          <= 1'b0;
			mode_rdata_o   <= pcm_pkg::MODE_RESET;
			ctrl_rdata_o   <= 8'h00;
			count_o        <= 16'h0000;
			wdog_enabled_o <= 1'b1;
		end
		else
		begin
			irq_o          <= nxt_irq;
			mode_rdata_o   <= mode_ff;
			ctrl_rdata_o   <= {ovf_ff, run_ff, 6'h00};
			count_o        <= cnt_ff;
			wdog_enabled_o <= wd_on;
		end
	end

	// ==========================================
	// Checks
	chk_irq_follows_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == $past(ovf_ff && mode_ff[pcm_pkg::IRQ_EN_BIT]))
		else $error("irq does not follow flag and mask");
	chk_wdog_reset_on: assert property (@(posedge clk_i)
		rst_i |=> mode_ff[pcm_pkg::WDOG_EN_BIT])
		else $error("watchdog not enabled after reset");
	chk_lock_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		locked |=> locked && mode_ff[pcm_pkg::WDOG_EN_BIT])
		else $error("locked watchdog was disabled");
	chk_unlock_disable: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_mode && !locked && !wdata_i[pcm_pkg::WDOG_EN_BIT] && !wdata_i[pcm_pkg::WDOG_LOCK_BIT]
		|=> !wd_on)
		else $error("watchdog not disabled by clear");
	chk_src_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		wd_on |=> $stable(src) && $stable(mode_ff[pcm_pkg::IDLE_BIT]))
		else $error("frozen field changed");
	chk_ovf_set: assert property (@(posedge clk_i) disable iff (rst_i)
		roll |=> ovf_ff && cnt_ff == 16'h0000)
		else $error("overflow not flagged");
	chk_ovf_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_ff && !wr_ctrl |=> ovf_ff)
		else $error("flag cleared by itself");
	chk_idle_halt: assert property (@(posedge clk_i) disable iff (rst_i)
		halted |=> $stable(cnt_ff))
		else $error("counted in idle");
	chk_sys_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		src == pcm_pkg::SRC_SYS && running && !halted |=> cnt_ff == $past(cnt_ff) + 16'h0001)
		else $error("sysclk source did not count");
	chk_reserved_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		src == 3'h7 |=> $stable(cnt_ff))
		else $error("reserved source counted");
	chk_lock_sets_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_mode && wdata_i[pcm_pkg::WDOG_LOCK_BIT] |=> locked && wd_on)
		else $error("lock write did not enable watchdog");
	chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && !wdata_i[pcm_pkg::OVF_BIT] && !roll |=> !ovf_ff)
		else $error("overflow flag not cleared");
	chk_t0_count: assert property (@(posedge clk_i) disable iff (rst_i)
		src == pcm_pkg::SRC_T0OVF && t0_tick && running && !halted
		|=> cnt_ff == $past(cnt_ff) + 16'h0001)
		else $error("timer 0 overflow not counted");
	chk_fall_count: assert property (@(posedge clk_i) disable iff (rst_i)
		src == pcm_pkg::SRC_EXTCNT && xcnt_fall && running && !halted
		|=> cnt_ff == $past(cnt_ff) + 16'h0001)
		else $error("falling edge not counted");
	chk_ext_count: assert property (@(posedge clk_i) disable iff (rst_i)
		src == pcm_pkg::SRC_EXT8 && ext_tick && running && !halted
		|=> cnt_ff == $past(cnt_ff) + 16'h0001)
		else $error("divided external clock not counted");
	cov_roll: cover property (@(posedge clk_i) disable iff (rst_i) roll);
	cov_t0: cover property (@(posedge clk_i) disable iff (rst_i) t0_tick && adv);
	cov_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
	cov_ext: cover property (@(posedge clk_i) disable iff (rst_i) ext_tick && adv);
	cov_xcnt: cover property (@(posedge clk_i) disable iff (rst_i) xcnt_fall && adv);
endmodule : pcm_mode_ctrl

/* tb/pcm_mode_ctrl_bench.sv */
module pcm_mode_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, rst_i = 1, wr_i = 0, cpu_idle_i = 0, t0_ovf_i = 0;
	logic        ext_count_i = 1, ext_clk_i = 0, tick_o, wdog_enabled_o, irq_o;
	logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, mode_rdata_o, ctrl_rdata_o;
	logic [7:0]  m = pcm_pkg::MODE_RESET;
	logic [15:0] count_o, c0;
	logic [2:0]  src [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
	int          per [4] = '{4, 12, 48, 0};
	int          errors = 0, total_checks = 0, k;
	always #5 clk_i = ~clk_i;
	pcm_mode_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
		.wdata_i(wdata_i), .cpu_idle_i(cpu_idle_i), .t0_ovf_i(t0_ovf_i),
		.ext_count_i(ext_count_i), .ext_clk_i(ext_clk_i), .mode_rdata_o(mode_rdata_o),
		.ctrl_rdata_o(ctrl_rdata_o), .count_o(count_o), .tick_o(tick_o),
		.wdog_enabled_o(wdog_enabled_o), .irq_o(irq_o));
	// ==========================================
	// Helpers
	task chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// Mode writes also update the reference copy of the register
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] n;
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		n = d & 8'hef;
		if (m[5]) n[5] = 1'b1;
		if (n[5]) n[6] = 1'b1;
		if (m[6] | m[5])
		begin
			n[7] = m[7];
			n[3:1] = m[3:1];
		end
		if (a == pcm_pkg::MODE_ADDR) m = n;
		repeat (3) @(posedge clk_i);
	endtask : wr
	task meas(input int n, input int e);
		c0 = count_o;
		repeat (n) @(posedge clk_i);
		chk(count_o - c0, 16'(e));
	endtask : meas
	// Allows for the input synchronisers before reading the count
	task fin(input int e);
		repeat (8) @(posedge clk_i);
		chk(count_o - c0, 16'(e));
	endtask : fin
	task test_done();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	// ==========================================
	// Watchdog
	initial
	begin
		#900us;
		errors++;
		test_done();
	end
	// ==========================================
	// Tests
	initial
	begin
		k = $urandom(32'h15eb);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(mode_rdata_o, 8'h40);
		chk(wdog_enabled_o, 1'b1);
		wr(pcm_pkg::MODE_ADDR, 8'h40 | 8'($urandom & 8'h9f));
		chk(mode_rdata_o, m);
		wr(pcm_pkg::MODE_ADDR, 8'h00);
		chk(mode_rdata_o, m);
		chk(wdog_enabled_o, 1'b0);
		wr(pcm_pkg::CTRL_ADDR, 8'h40);
		for (int i = 0; i < 4; i++)
		begin
			wr(pcm_pkg::MODE_ADDR, {4'h0, src[i], 1'b0});
			meas(48, per[i]);
		end
		wr(pcm_pkg::MODE_ADDR, 8'h04);
		c0 = count_o;
		k = 1 + $urandom % 6;
		repeat (k)
		begin
			t0_ovf_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			t0_ovf_i <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		fin(k);
		wr(pcm_pkg::MODE_ADDR, 8'h06);
		c0 = count_o;
		k = 1 + $urandom % 9;
		// Falling edges at one eighth of the clock, inside the allowed rate
		repeat (k)
		begin
			ext_count_i <= 1'b0;
			repeat (4) @(posedge clk_i);
			ext_count_i <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
		fin(k);
		wr(pcm_pkg::MODE_ADDR, 8'h0a);
		c0 = count_o;
		// A whole multiple of eight edges hides the divider's start phase
		repeat (64)
		begin
			ext_clk_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			ext_clk_i <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		fin(8);
		cpu_idle_i <= 1'b1;
		wr(pcm_pkg::MODE_ADDR, 8'h88);
		meas(48, 0);
		chk(tick_o, 1'b0);
		wr(pcm_pkg::MODE_ADDR, 8'h09);
		meas(48, 48);
		chk(tick_o, 1'b1);
		k = 0;
		while (ctrl_rdata_o[7] !== 1'b1 && k < 70000)
		begin
			@(posedge clk_i);
			k++;
		end
		chk(k < 70000, 1'b1);
		chk(count_o < 16'h0004, 1'b1);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b1);
		wr(pcm_pkg::MODE_ADDR, 8'h08);
		chk(irq_o, 1'b0);
		chk(ctrl_rdata_o, 8'hc0);
		wr(pcm_pkg::MODE_ADDR, 8'h20);
		chk(mode_rdata_o, m);
		wr(pcm_pkg::MODE_ADDR, 8'($urandom & 8'h9f));
		chk(mode_rdata_o, m);
		chk(wdog_enabled_o, 1'b1);
		test_done();
	end
endmodule : pcm_mode_ctrl_bench
